/* amx_pkg.sv */
// Shared constants and carriers for the arithmetic, memory and operand exception unit.
// Assumes a 200 MHz processor clock and an APB master on the register side.
package amx_pkg;

  // ****************************************************
  // Arithmetic type codes
  // ****************************************************
  localparam logic [3:0] AMX_TC_NONE = 4'h0;
  localparam logic [3:0] AMX_TC_INT_OVF_T = 4'h1;
  localparam logic [3:0] AMX_TC_INT_DIV_T = 4'h2;
  localparam logic [3:0] AMX_TC_FLT_OVF_T = 4'h3;
  localparam logic [3:0] AMX_TC_DIV_ZERO_T = 4'h4;
  localparam logic [3:0] AMX_TC_FLT_UND_T = 4'h5;
  localparam logic [3:0] AMX_TC_DEC_OVF_T = 4'h6;
  localparam logic [3:0] AMX_TC_SUB_RNG_T = 4'h7;
  localparam logic [3:0] AMX_TC_FLT_OVF_F = 4'h8;
  localparam logic [3:0] AMX_TC_FLT_DIV_F = 4'h9;
  localparam logic [3:0] AMX_TC_FLT_UND_F = 4'ha;

  // ****************************************************
  // Exception classes (vector select)
  // ****************************************************
  typedef enum logic [2:0] {
    AMX_VEC_NONE,
    AMX_VEC_ARITH,
    AMX_VEC_ACV,
    AMX_VEC_TNV,
    AMX_VEC_RES_ADDR,
    AMX_VEC_RES_OPND
  } amx_vec_e;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [11:0] AMX_OFS_CTRL = 12'h000;
  localparam logic [11:0] AMX_OFS_STATUS = 12'h004;
  localparam logic [11:0] AMX_OFS_RESULT = 12'h008;
  localparam logic [11:0] AMX_OFS_COUNT = 12'h00c;
  localparam int AMX_CTRL_INT_OVF_EN = 0;
  localparam int AMX_CTRL_FLT_UND_EN = 1;
  localparam int AMX_CTRL_DEC_OVF_EN = 2;
  localparam logic [2:0] AMX_CTRL_RST = 3'h0;

  // Floating field positions (F format, sign at 15, exponent 14:7)
  localparam int AMX_FLT_SIGN = 15;
  localparam int AMX_FLT_EXP_HI = 14;
  localparam int AMX_FLT_EXP_LO = 7;
  localparam logic [31:0] AMX_FLT_RESOP = 32'h0000_8000;

  // ****************************************************
  // Carriers
  // ****************************************************
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } amx_cc_s;

  // Conditions reported by the execution datapath for one instruction
  typedef struct packed {
    logic done;
    logic no_ovf_op;
    logic polynomial_evaluate_op;
    logic int_ovf;
    logic int_div0;
    logic flt_ovf;
    logic flt_div0;
    logic dec_div0;
    logic flt_und;
    logic dec_ovf;
    logic sub_rng;
    logic flt_fault_form;
    logic acv;
    logic tnv;
    logic lit_bad;
    logic reg_bad;
    logic idx_bad;
    logic flt_opnd_chk;
    logic [31:0] flt_opnd;
    logic [31:0] true_low;
    logic [31:0] dividend;
    amx_cc_s cc_in;
    logic [31:0] pc_cur;
    logic [31:0] pc_next;
  } amx_req_s;

  // Report to the stack and vector dispatch
  typedef struct packed {
    logic valid;
    amx_vec_e vec;
    logic push_code;
    logic [31:0] type_code;
    logic [31:0] saved_pc;
    logic store_result;
    logic [31:0] result;
    logic cc_valid;
    amx_cc_s cc;
    logic set_first_part_done_flag;
    logic clr_first_part_done_trace_pending;
  } amx_rpt_s;

endpackage : amx_pkg

/* amx_unit.sv */
// Exception detection and reporting for arithmetic, memory management and operand faults.
// Assumes the datapath presents one instruction's conditions per cycle on req, synchronous to pclk.
module amx_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Datapath conditions
  input wire amx_pkg::amx_req_s req,
  // Report to dispatch
  output amx_pkg::amx_rpt_s rpt
);

  // ****************************************************
  // Control register and APB
  // ****************************************************
  logic [2:0] ctrl_r;
  amx_pkg::amx_rpt_s rpt_nxt;
  logic [31:0] count_r;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  amx_pkg::amx_vec_e last_vec_r;
  logic [3:0] last_code_r;
  logic [31:0] last_result_r;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign addr_ok = (paddr == amx_pkg::AMX_OFS_CTRL) || (paddr == amx_pkg::AMX_OFS_STATUS) ||
                   (paddr == amx_pkg::AMX_OFS_RESULT) || (paddr == amx_pkg::AMX_OFS_COUNT);
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= amx_pkg::AMX_CTRL_RST;
    end else if (apb_wr && paddr == amx_pkg::AMX_OFS_CTRL) begin
      ctrl_r <= pwdata[2:0];
    end
  end

  // ****************************************************
  // APB read path
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      unique case (paddr)
        amx_pkg::AMX_OFS_CTRL: prdata <= {29'h0000_0000, ctrl_r};
        amx_pkg::AMX_OFS_STATUS: prdata <= {25'h000_0000, last_vec_r, last_code_r};
        amx_pkg::AMX_OFS_RESULT: prdata <= last_result_r;
        amx_pkg::AMX_OFS_COUNT: prdata <= count_r;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************
  // Detection and priority
  // ****************************************************
  logic int_overflow_trap_enable;
  logic float_underflow_trap_enable;
  logic decimal_overflow_trap_enable;
  logic flt_resop;
  logic res_addr;
  logic [3:0] code;

  assign int_overflow_trap_enable = ctrl_r[amx_pkg::AMX_CTRL_INT_OVF_EN];
  assign float_underflow_trap_enable = ctrl_r[amx_pkg::AMX_CTRL_FLT_UND_EN];
  assign decimal_overflow_trap_enable = ctrl_r[amx_pkg::AMX_CTRL_DEC_OVF_EN];
  // Sign set, exponent zero, in any operand or coefficient
  assign flt_resop = req.flt_opnd_chk && req.flt_opnd[amx_pkg::AMX_FLT_SIGN] &&
                     (req.flt_opnd[amx_pkg::AMX_FLT_EXP_HI:amx_pkg::AMX_FLT_EXP_LO] == 8'h00);
  assign res_addr = req.lit_bad || req.reg_bad || req.idx_bad;

  // ****************************************************
  // Arithmetic code priority
  // ****************************************************
  // Priority-ordered arithmetic code selection, one at most
  always_comb begin
    code = amx_pkg::AMX_TC_NONE;
    if (req.int_ovf && int_overflow_trap_enable && !req.no_ovf_op) begin
      code = amx_pkg::AMX_TC_INT_OVF_T;
    end else if (req.int_div0) begin
      code = amx_pkg::AMX_TC_INT_DIV_T;
    end else if (req.flt_ovf) begin
      code = req.flt_fault_form ? amx_pkg::AMX_TC_FLT_OVF_F : amx_pkg::AMX_TC_FLT_OVF_T;
    end else if (req.flt_div0) begin
      code = req.flt_fault_form ? amx_pkg::AMX_TC_FLT_DIV_F : amx_pkg::AMX_TC_DIV_ZERO_T;
    end else if (req.dec_div0) begin
      code = amx_pkg::AMX_TC_DIV_ZERO_T;
    end else if (req.flt_und && float_underflow_trap_enable) begin
      code = req.flt_fault_form ? amx_pkg::AMX_TC_FLT_UND_F : amx_pkg::AMX_TC_FLT_UND_T;
    end else if (req.dec_ovf && decimal_overflow_trap_enable) begin
      code = amx_pkg::AMX_TC_DEC_OVF_T;
    end else if (req.sub_rng) begin
      code = amx_pkg::AMX_TC_SUB_RNG_T;
    end
  end

  // ****************************************************
  // Report construction
  // ****************************************************
  always_comb begin
    rpt_nxt = '0;
    rpt_nxt.vec = amx_pkg::AMX_VEC_NONE;
    rpt_nxt.cc = req.cc_in;
    if (req.done) begin
      if (req.acv) begin
        rpt_nxt.valid = 1'b1;
        rpt_nxt.vec = amx_pkg::AMX_VEC_ACV;
        rpt_nxt.saved_pc = req.pc_cur;
        rpt_nxt.clr_first_part_done_trace_pending = 1'b0;
      end else if (req.tnv) begin
        rpt_nxt.valid = 1'b1;
        rpt_nxt.vec = amx_pkg::AMX_VEC_TNV;
        rpt_nxt.saved_pc = req.pc_cur;
      end else if (res_addr) begin
        rpt_nxt.valid = 1'b1;
        rpt_nxt.vec = amx_pkg::AMX_VEC_RES_ADDR;
        rpt_nxt.saved_pc = req.pc_cur;
      end else if (flt_resop) begin
        rpt_nxt.valid = 1'b1;
        rpt_nxt.vec = amx_pkg::AMX_VEC_RES_OPND;
        rpt_nxt.saved_pc = req.pc_cur;
        rpt_nxt.clr_first_part_done_trace_pending = 1'b1;
      end else if (code != amx_pkg::AMX_TC_NONE) begin
        rpt_nxt.valid = 1'b1;
        rpt_nxt.vec = amx_pkg::AMX_VEC_ARITH;
        rpt_nxt.push_code = 1'b1;
        rpt_nxt.type_code = {28'h000_0000, code};
        // Faults back up, traps complete
        rpt_nxt.saved_pc = (code >= amx_pkg::AMX_TC_FLT_OVF_F)
                           ? req.pc_cur : req.pc_next;
        unique case (code)
          amx_pkg::AMX_TC_INT_OVF_T: begin
            rpt_nxt.store_result = 1'b1;
            rpt_nxt.result = req.true_low;
            rpt_nxt.cc_valid = 1'b1;
            rpt_nxt.cc.n = req.true_low[31];
            rpt_nxt.cc.z = (req.true_low == 32'h0000_0000);
            rpt_nxt.cc.v = 1'b1;
          end
          amx_pkg::AMX_TC_INT_DIV_T: begin
            rpt_nxt.store_result = 1'b1;
            rpt_nxt.result = req.dividend;
            rpt_nxt.cc_valid = 1'b1;
            rpt_nxt.cc.v = 1'b1;
          end
          amx_pkg::AMX_TC_FLT_OVF_T, amx_pkg::AMX_TC_DIV_ZERO_T: begin
            if (!req.dec_div0 || req.flt_ovf || req.flt_div0) begin
              rpt_nxt.store_result = 1'b1;
              rpt_nxt.result = amx_pkg::AMX_FLT_RESOP;
              rpt_nxt.cc_valid = 1'b1;
              rpt_nxt.cc = '{n: 1'b1, z: 1'b0, v: 1'b1, c: 1'b0};
            end
          end
          amx_pkg::AMX_TC_FLT_UND_T: begin
            rpt_nxt.store_result = 1'b1;
            rpt_nxt.result = 32'h0000_0000;
            rpt_nxt.cc_valid = 1'b1;
            if (!req.polynomial_evaluate_op) begin
              rpt_nxt.cc = '{n: 1'b0, z: 1'b1, v: 1'b0, c: 1'b0};
            end
          end
          amx_pkg::AMX_TC_DEC_OVF_T: begin
            rpt_nxt.cc_valid = 1'b1;
            rpt_nxt.cc.v = 1'b1;
          end
          amx_pkg::AMX_TC_SUB_RNG_T: begin
            rpt_nxt.store_result = 1'b1;
            rpt_nxt.result = req.true_low;
            rpt_nxt.cc_valid = 1'b1;
          end
          amx_pkg::AMX_TC_FLT_OVF_F, amx_pkg::AMX_TC_FLT_UND_F: begin
            rpt_nxt.set_first_part_done_flag = req.polynomial_evaluate_op;
          end
          default: begin
            rpt_nxt.store_result = 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************
  // Registered report, one block per concern
  // ****************************************************
  logic valid_r;
  amx_pkg::amx_vec_e vec_r;
  logic push_code_r;
  logic [31:0] type_code_r;
  logic [31:0] saved_pc_r;
  logic store_result_r;
  logic [31:0] result_r;
  logic cc_valid_r;
  amx_pkg::amx_cc_s cc_r;
  logic set_first_part_done_r;
  logic clr_flags_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_r <= 1'b0;
      vec_r <= amx_pkg::AMX_VEC_NONE;
    end else begin
      valid_r <= rpt_nxt.valid;
      vec_r <= rpt_nxt.vec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_code_r <= 1'b0;
      type_code_r <= 32'h0000_0000;
    end else begin
      push_code_r <= rpt_nxt.push_code;
      type_code_r <= rpt_nxt.type_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_pc_r <= 32'h0000_0000;
    end else begin
      saved_pc_r <= rpt_nxt.saved_pc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_result_r <= 1'b0;
      result_r <= 32'h0000_0000;
    end else begin
      store_result_r <= rpt_nxt.store_result;
      result_r <= rpt_nxt.result;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_valid_r <= 1'b0;
      cc_r <= '0;
    end else begin
      cc_valid_r <= rpt_nxt.cc_valid;
      cc_r <= rpt_nxt.cc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_first_part_done_r <= 1'b0;
      clr_flags_r <= 1'b0;
    end else begin
      set_first_part_done_r <= rpt_nxt.set_first_part_done_flag;
      clr_flags_r <= rpt_nxt.clr_first_part_done_trace_pending;
    end
  end

  // ****************************************************
  // Report outputs, straight from the flops
  // ****************************************************
  always_comb begin
    rpt.valid = valid_r;
    rpt.vec = vec_r;
    rpt.push_code = push_code_r;
    rpt.type_code = type_code_r;
    rpt.saved_pc = saved_pc_r;
    rpt.store_result = store_result_r;
    rpt.result = result_r;
    rpt.cc_valid = cc_valid_r;
    rpt.cc = cc_r;
    rpt.set_first_part_done_flag = set_first_part_done_r;
    rpt.clr_first_part_done_trace_pending = clr_flags_r;
  end

  // ****************************************************
  // Last exception, held for software reads
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_vec_r <= amx_pkg::AMX_VEC_NONE;
    end else if (rpt_nxt.valid) begin
      last_vec_r <= rpt_nxt.vec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_code_r <= 4'h0;
    end else if (rpt_nxt.valid) begin
      last_code_r <= rpt_nxt.type_code[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_result_r <= 32'h0000_0000;
    end else if (rpt_nxt.valid) begin
      last_result_r <= rpt_nxt.result;
    end
  end

  // ****************************************************
  // Event count
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 32'h0000_0000;
    end else if (apb_wr && paddr == amx_pkg::AMX_OFS_COUNT) begin
      count_r <= 32'h0000_0000;
    end else if (rpt_nxt.valid) begin
      count_r <= count_r + 32'h0000_0001;
    end
  end

endmodule : amx_unit

/* amx_unit_chk.sv */
// Port checker for the exception unit.
// Bound to every amx_unit instance.
module amx_unit_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Datapath and report
  input wire amx_pkg::amx_req_s req,
  input wire amx_pkg::amx_rpt_s rpt
);
  // ****
  // Properties
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mm;
  logic ar;
  assign mm = req.acv | req.tnv | req.lit_bad | req.reg_bad | req.idx_bad;
  assign ar = rpt.valid && rpt.vec == amx_pkg::AMX_VEC_ARITH;
  sequence s_div0;
    req.done && !mm && !req.flt_opnd_chk && req.int_div0 && !req.int_ovf;
  endsequence
  sequence s_badf;
    req.done && !mm && req.flt_opnd_chk && req.flt_opnd[15] && req.flt_opnd[14:7] == 8'h0;
  endsequence
  a_from_req: assert property (rpt.valid |-> $past(req.done)) else $error("rpt unasked");
  a_code_low: assert property (ar |-> rpt.push_code && rpt.type_code[31:4] == 28'h0
    && rpt.type_code != 32'h0) else $error("code bad");
  a_int_ovf: assert property (ar && rpt.type_code == 32'h1 |-> $past(req.int_ovf && !req.no_ovf_op)
    && rpt.cc.n == rpt.result[31] && rpt.cc.z == (rpt.result == 32'h0)) else $error("int ovf");
  a_div_zero: assert property (s_div0 |=> rpt.valid && rpt.type_code == 32'h2
    && rpt.result == $past(req.dividend) && rpt.cc.v) else $error("int div0");
  a_trap_pc: assert property (ar && rpt.type_code < 32'h8 |-> rpt.saved_pc == $past(req.pc_next))
    else $error("trap pc");
  a_fault_pc: assert property (ar && rpt.type_code >= 32'h8 |-> rpt.saved_pc == $past(req.pc_cur)
    && !rpt.store_result) else $error("fault pc");
  a_flt_resop: assert property (ar && (rpt.type_code == 32'h3 || rpt.type_code == 32'h4 && $past(req.flt_div0))
    |-> rpt.result == amx_pkg::AMX_FLT_RESOP && rpt.cc == 4'b1010) else $error("flt resop");
  a_und_zero: assert property (ar && rpt.type_code == 32'h5 && !$past(req.polynomial_evaluate_op)
    |-> rpt.result == 32'h0 && rpt.cc == 4'b0100) else $error("flt und");
  a_acv_first: assert property (req.done && req.acv |=> rpt.valid && rpt.vec == amx_pkg::AMX_VEC_ACV)
    else $error("acv");
  a_res_addr: assert property (req.done && !req.acv && !req.tnv && (req.lit_bad | req.reg_bad | req.idx_bad)
    |=> rpt.valid && rpt.vec == amx_pkg::AMX_VEC_RES_ADDR && !rpt.push_code) else $error("res addr");
  a_res_opnd: assert property (s_badf |=> rpt.valid && rpt.vec == amx_pkg::AMX_VEC_RES_OPND
    && !rpt.push_code && rpt.saved_pc == $past(req.pc_cur) && !rpt.cc_valid) else $error("res opnd");
endmodule : amx_unit_chk
bind amx_unit amx_unit_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req), .rpt(rpt));

/* amx_disp.sv */
// Dispatch model: latches each reported frame.
// Assumes rpt is registered on pclk.
module amx_disp (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Report in
  input wire amx_pkg::amx_rpt_s rpt,
  // Captured frame
  output logic got,
  output amx_pkg::amx_rpt_s frame
);
  // ****
  // Frame capture
  // ****
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got <= 1'b0;
      frame <= '0;
    end else begin
      got <= rpt.valid;
      if (rpt.valid) frame <= rpt;
    end
  end
endmodule : amx_disp

/* tb_amx_unit.sv */
// Testbench for amx_unit with dispatch model.
// Assumes amx_pkg, amx_unit, amx_disp compiled first.
module tb_amx_unit;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Signals
  // ****
  typedef struct packed {
    amx_pkg::amx_vec_e vec;
    logic [3:0] code;
    logic [31:0] pc;
    logic [31:0] res;
    logic sr;
  } amx_exp_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, got, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, last_res;
  logic [31:0] seed = 32'hce1e;
  amx_pkg::amx_req_s req;
  amx_pkg::amx_rpt_s rpt, frame;
  amx_exp_s expq[$];
  amx_exp_s em;
  int num_errors = 0;
  int check_count = 0;
  always #2.5 pclk = ~pclk;
  amx_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req), .rpt(rpt));
  amx_disp dsp (.pclk(pclk), .presetn(presetn), .rpt(rpt), .got(got), .frame(frame));
  // ****
  // Tasks
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task run(input int k, input logic en);
    amx_pkg::amx_req_s r;
    amx_exp_s x;
    r = '0;
    x = '0;
    r.done = 1'b1;
    seed = xs(seed);
    r.pc_cur = seed;
    r.pc_next = seed + 32'h4;
    seed = xs(seed);
    r.true_low = seed;
    r.dividend = ~seed;
    x.vec = amx_pkg::AMX_VEC_ARITH;
    x.pc = r.pc_next;
    x.sr = 1'b1;
    case (k)
      0: begin r.int_ovf = 1'b1; x.code = 4'h1; x.res = r.true_low; end
      1: begin r.int_div0 = 1'b1; x.code = 4'h2; x.res = r.dividend; end
      2: begin r.flt_ovf = 1'b1; x.code = 4'h3; x.res = amx_pkg::AMX_FLT_RESOP; end
      3: begin r.flt_div0 = 1'b1; x.code = 4'h4; x.res = amx_pkg::AMX_FLT_RESOP; end
      4: begin r.dec_div0 = 1'b1; x.code = 4'h4; x.sr = 1'b0; end
      5: begin r.flt_und = 1'b1; x.code = 4'h5; end
      6: begin r.dec_ovf = 1'b1; x.code = 4'h6; x.sr = 1'b0; end
      7: begin r.sub_rng = 1'b1; x.code = 4'h7; x.res = r.true_low; end
      8: begin r.flt_ovf = 1'b1; x.code = 4'h8; end
      9: begin r.flt_div0 = 1'b1; x.code = 4'h9; end
      10: begin r.flt_und = 1'b1; x.code = 4'ha; end
      11: begin r.acv = 1'b1; r.tnv = 1'b1; x.vec = amx_pkg::AMX_VEC_ACV; end
      12: begin r.tnv = 1'b1; x.vec = amx_pkg::AMX_VEC_TNV; end
      13: begin r.lit_bad = 1'b1; r.int_ovf = 1'b1; x.vec = amx_pkg::AMX_VEC_RES_ADDR; end
      14: begin r.reg_bad = 1'b1; x.vec = amx_pkg::AMX_VEC_RES_ADDR; end
      15: begin r.idx_bad = 1'b1; x.vec = amx_pkg::AMX_VEC_RES_ADDR; end
      16: begin r.flt_opnd_chk = 1'b1; r.flt_opnd = 32'h8000 | (seed & 32'h7f); x.vec = amx_pkg::AMX_VEC_RES_OPND; end
      default: begin r.int_ovf = 1'b1; r.no_ovf_op = 1'b1; end
    endcase
    if (k >= 8 && k <= 10) r.flt_fault_form = 1'b1;
    if (k >= 8) begin
      x.pc = r.pc_cur;
      x.sr = 1'b0;
    end
    if (k < 17 && (en || k == 1)) begin
      expq.push_back(x);
      last_res = x.res;
    end
    req <= r;
    @(posedge pclk);
  endtask : run
  task conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // ****
  // Monitor and sequence
  // ****
  always @(posedge pclk) begin
    if (got) begin
      if (expq.size() == 0) begin
        num_errors++;
        $display("[ERR] rpt exp none got %h", frame.type_code);
      end else begin
        em = expq.pop_front();
        chk("vec", 32'(em.vec), 32'(frame.vec));
        chk("pc", em.pc, frame.saved_pc);
        if (em.vec == amx_pkg::AMX_VEC_ARITH) chk("code", {28'h0, em.code}, frame.type_code);
        if (em.sr) chk("res", em.res, frame.result);
      end
    end
  end
  initial begin
    repeat (3000) @(posedge pclk);
    num_errors++;
    $display("[ERR] run exp end got hang");
    conclude();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    req = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, q, e);
    chk("ctrl0", 32'h0, q);
    apb(1'b1, 12'h000, 32'h7, q, e);
    apb(1'b0, 12'h000, 32'h0, q, e);
    chk("ctrl", 32'h7, q);
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk("slverr", 32'h1, {31'h0, e});
    $display("regs done");
    for (int k = 0; k < 18; k++) run(k, 1'b1);
    req <= '0;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h00c, 32'h0, q, e);
    chk("count", 32'd17, q);
    $display("codes done");
    apb(1'b1, 12'h000, 32'h0, q, e);
    run(0, 1'b0);
    run(1, 1'b0);
    run(5, 1'b0);
    run(10, 1'b0);
    req <= '0;
    repeat (4) @(posedge pclk);
    chk("left", 32'h0, 32'(expq.size()));
    apb(1'b0, 12'h004, 32'h0, q, e);
    chk("status", {25'h0, amx_pkg::AMX_VEC_ARITH, amx_pkg::AMX_TC_INT_DIV_T}, q);
    apb(1'b0, 12'h008, 32'h0, q, e);
    chk("result", last_res, q);
    $display("gated done");
    conclude();
  end
endmodule : tb_amx_unit
